// ---- common/crosspoint_host_pkg.sv ----
package crosspoint_host_pkg;

   // ****************************************
   // Geometry of the switch port
   // ****************************************
   localparam int OUT_COUNT = 17;
   localparam int IN_COUNT = 33;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 7;
   localparam int INPUT_NUM_W = 6;
   localparam int ENABLE_BIT = 6;
   localparam logic [4:0] BROADCAST_ADDR = 5'h11;

   // ****************************************
   // Own registers on the bus
   // ****************************************
   localparam logic [31:0] CMD_OFFSET = 32'h0000_0000;
   localparam logic [31:0] STATUS_OFFSET = 32'h0000_0004;
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_ADDR_LSB = 8;
   localparam int CMD_DATA_LSB = 16;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_ERROR_BIT = 1;
   localparam int STAT_VALID_BIT = 2;
   localparam int STAT_RDATA_LSB = 8;

   // ****************************************
   // Commands
   // ****************************************
   localparam logic [1:0] OP_RESET = 2'h0;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_UPDATE = 2'h2;
   localparam logic [1:0] OP_READ = 2'h3;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [1:0] CMD_OP_RESET = 2'h0;
   localparam logic [4:0] CMD_ADDR_RESET = 5'h00;
   localparam logic [6:0] CMD_DATA_RESET = 7'h00;
   localparam logic [6:0] RDATA_RESET = 7'h00;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int STEP_NS = 15;
   localparam int STEP_CYCLES = (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READ_WAIT_STEPS = 3;

endpackage

// ---- verilog/step_divider.sv ----
module step_divider (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Step enable
   output logic step_en
);

   logic [3:0] count_q;

   // ****************************************
   // Free running step divider
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_q <= 4'h0;
         step_en <= 1'b0;
      end else if (count_q == 4'(crosspoint_host_pkg::STEP_CYCLES - 1)) begin
         count_q <= 4'h0;
         step_en <= 1'b1;
      end else begin
         count_q <= count_q + 4'h1;
         step_en <= 1'b0;
      end
   end

endmodule

// ---- verilog/pin_sync.sv ----
module pin_sync (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Pins and synchronised value
   input wire logic [6:0] pin_in,
   output logic [6:0] pin_out
);

   logic [6:0] s1_q;
   logic [6:0] s2_q;
   logic [6:0] s3_q;

   // ****************************************
   // Three stages, accept once two agree
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_q <= 7'h00;
         s2_q <= 7'h00;
         s3_q <= 7'h00;
         pin_out <= 7'h00;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (int i = 0; i < 7; i++) begin
            if (s2_q[i] == s3_q[i]) begin
               pin_out[i] <= s3_q[i];
            end
         end
      end
   end

endmodule

// ---- verilog/crosspoint_host.sv ----
module crosspoint_host (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Switch control pins
   output logic sw_cs_n,
   output logic sw_we_n,
   output logic readback_enable_n,
   output logic sw_update_n,
   output logic sw_reset_n,
   output logic [4:0] sw_addr,
   output logic [6:0] sw_data_o,
   output logic sw_data_oe,
   input wire logic [6:0] sw_data_i
);

   typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_RELEASE, ST_FINISH, ST_RST_HOLD} state_t;

   state_t state_q;
   logic step_en;
   logic [6:0] data_sync;
   logic go_q;
   logic [1:0] op_q;
   logic [4:0] cmd_addr_q;
   logic [6:0] cmd_data_q;
   logic error_q;
   logic valid_q;
   logic [6:0] rdata_q;
   logic [1:0] wait_q;
   logic wr_pend_q;
   logic [31:0] wr_addr_q;
   logic busy;
   logic cmd_wr;
   logic cmd_ok;
   logic err_clr;
   logic [1:0] new_op;
   logic [4:0] new_addr;
   logic [6:0] new_data;
   logic [crosspoint_host_pkg::OUT_COUNT-1:0] written_q;

   function automatic logic addr_is_out(input logic [4:0] a);
      return a < 5'(crosspoint_host_pkg::OUT_COUNT);
   endfunction

   // ****************************************
   // Helpers
   // ****************************************
   step_divider u_step (
      .hclk(hclk),
      .hresetn(hresetn),
      .step_en(step_en)
   );

   pin_sync u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin_in(sw_data_i),
      .pin_out(data_sync)
   );

   // ****************************************
   // Command decode and checks
   // ****************************************
   assign busy = (state_q != ST_IDLE) || go_q;
   assign new_op = hwdata[crosspoint_host_pkg::CMD_OP_LSB +: 2];
   assign new_addr = hwdata[crosspoint_host_pkg::CMD_ADDR_LSB +: 5];
   assign new_data = hwdata[crosspoint_host_pkg::CMD_DATA_LSB +: 7];
   assign cmd_wr = wr_pend_q && (wr_addr_q == crosspoint_host_pkg::CMD_OFFSET);
   assign err_clr = wr_pend_q && (wr_addr_q == crosspoint_host_pkg::STATUS_OFFSET)
                    && hwdata[crosspoint_host_pkg::STAT_ERROR_BIT];

   always_comb begin
      cmd_ok = !busy;
      if (new_op == crosspoint_host_pkg::OP_WRITE) begin
         // Reserved codes are refused, broadcast is allowed for writes
         if (!(addr_is_out(new_addr) || new_addr == crosspoint_host_pkg::BROADCAST_ADDR)) begin
            cmd_ok = 1'b0;
         end
         if (new_data[5:0] >= 6'(crosspoint_host_pkg::IN_COUNT)) begin
            cmd_ok = 1'b0;
         end
      end else if (new_op == crosspoint_host_pkg::OP_READ) begin
         // Broadcast readback gives no valid word
         if (!addr_is_out(new_addr)) begin
            cmd_ok = 1'b0;
         end
      end else if (new_op == crosspoint_host_pkg::OP_UPDATE) begin
         // Update is refused until every pending row holds a written word
         if (written_q != {crosspoint_host_pkg::OUT_COUNT{1'b1}}) begin
            cmd_ok = 1'b0;
         end
      end
   end

   // ****************************************
   // AHB-Lite slave, zero wait states
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 32'h0000_0000;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend_q <= 1'b0;
         hrdata <= 32'h0000_0000;
         if (hsel && hready && htrans[1]) begin
            if (hwrite) begin
               wr_pend_q <= 1'b1;
               wr_addr_q <= {haddr[31:2], 2'b00};
            end else if ({haddr[31:2], 2'b00} == crosspoint_host_pkg::CMD_OFFSET) begin
               hrdata[crosspoint_host_pkg::CMD_OP_LSB +: 2] <= op_q;
               hrdata[crosspoint_host_pkg::CMD_ADDR_LSB +: 5] <= cmd_addr_q;
               hrdata[crosspoint_host_pkg::CMD_DATA_LSB +: 7] <= cmd_data_q;
            end else if ({haddr[31:2], 2'b00} == crosspoint_host_pkg::STATUS_OFFSET) begin
               hrdata[crosspoint_host_pkg::STAT_BUSY_BIT] <= busy;
               hrdata[crosspoint_host_pkg::STAT_ERROR_BIT] <= error_q;
               hrdata[crosspoint_host_pkg::STAT_VALID_BIT] <= valid_q;
               hrdata[crosspoint_host_pkg::STAT_RDATA_LSB +: 7] <= rdata_q;
            end
         end
      end
   end

   // ****************************************
   // Command register
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         op_q <= crosspoint_host_pkg::CMD_OP_RESET;
         cmd_addr_q <= crosspoint_host_pkg::CMD_ADDR_RESET;
         cmd_data_q <= crosspoint_host_pkg::CMD_DATA_RESET;
         go_q <= 1'b0;
      end else if (cmd_wr && cmd_ok) begin
         op_q <= new_op;
         cmd_addr_q <= new_addr;
         cmd_data_q <= new_data;
         go_q <= 1'b1;
      end else if (state_q == ST_IDLE && step_en) begin
         go_q <= 1'b0;
      end
   end

   // Refused command flag, a new refusal beats the clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         error_q <= 1'b0;
      end else if (cmd_wr && !cmd_ok) begin
         error_q <= 1'b1;
      end else if (err_clr) begin
         error_q <= 1'b0;
      end
   end

   // ****************************************
   // Rows written since bus reset
   // ****************************************
   // Pin reset leaves pending rows alone, so only the bus reset clears this
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         written_q <= {crosspoint_host_pkg::OUT_COUNT{1'b0}};
      end else if (cmd_wr && cmd_ok && new_op == crosspoint_host_pkg::OP_WRITE) begin
         if (new_addr == crosspoint_host_pkg::BROADCAST_ADDR) begin
            written_q <= {crosspoint_host_pkg::OUT_COUNT{1'b1}};
         end else begin
            written_q[new_addr] <= 1'b1;
         end
      end
   end

   // ****************************************
   // Pin sequencer, one step per enable
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= ST_IDLE;
         sw_cs_n <= 1'b1;
         sw_we_n <= 1'b1;
         readback_enable_n <= 1'b1;
         sw_update_n <= 1'b1;
         sw_reset_n <= 1'b1;
         sw_addr <= 5'h00;
         sw_data_o <= 7'h00;
         sw_data_oe <= 1'b0;
         wait_q <= 2'h0;
      end else if (step_en) begin
         case (state_q)
            ST_IDLE: begin
               if (go_q) begin
                  if (op_q == crosspoint_host_pkg::OP_RESET) begin
                     // Global disable needs no chip select
                     sw_reset_n <= 1'b0;
                     state_q <= ST_RST_HOLD;
                  end else begin
                     sw_cs_n <= 1'b0;
                     sw_addr <= cmd_addr_q;
                     sw_data_o <= cmd_data_q;
                     // Never drive the bus while reading back
                     sw_data_oe <= (op_q == crosspoint_host_pkg::OP_WRITE);
                     state_q <= ST_SETUP;
                  end
               end
            end
            ST_SETUP: begin
               // Data already stood one full step, meeting the 15 ns setup
               if (op_q == crosspoint_host_pkg::OP_WRITE) begin
                  sw_we_n <= 1'b0;
               end else if (op_q == crosspoint_host_pkg::OP_UPDATE) begin
                  sw_update_n <= 1'b0;
               end else begin
                  readback_enable_n <= 1'b0;
               end
               wait_q <= 2'h0;
               state_q <= ST_STROBE;
            end
            ST_STROBE: begin
               if (op_q == crosspoint_host_pkg::OP_READ) begin
                  // Extra steps cover enable time plus synchroniser depth
                  if (wait_q == 2'(crosspoint_host_pkg::READ_WAIT_STEPS - 1)) begin
                     readback_enable_n <= 1'b1;
                     state_q <= ST_RELEASE;
                  end else begin
                     wait_q <= wait_q + 2'h1;
                  end
               end else begin
                  // Level strobe: raise it before anything else moves
                  sw_we_n <= 1'b1;
                  sw_update_n <= 1'b1;
                  state_q <= ST_RELEASE;
               end
            end
            ST_RELEASE: begin
               sw_cs_n <= 1'b1;
               sw_data_oe <= 1'b0;
               state_q <= ST_FINISH;
            end
            ST_RST_HOLD: begin
               sw_reset_n <= 1'b1;
               state_q <= ST_FINISH;
            end
            ST_FINISH: begin
               // Idle step lets the readback driver let go of the bus
               state_q <= ST_IDLE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // ****************************************
   // Readback capture
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_q <= crosspoint_host_pkg::RDATA_RESET;
         valid_q <= 1'b0;
      end else if (step_en && state_q == ST_STROBE && op_q == crosspoint_host_pkg::OP_READ
                   && wait_q == 2'(crosspoint_host_pkg::READ_WAIT_STEPS - 1)) begin
         rdata_q <= data_sync;
         valid_q <= 1'b1;
      end else if (cmd_wr && cmd_ok && new_op == crosspoint_host_pkg::OP_READ) begin
         valid_q <= 1'b0;
      end
   end

endmodule

// ---- tb/crosspoint_host_checker.sv ----
module crosspoint_host_checker (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Switch pins
   input wire logic sw_cs_n,
   input wire logic sw_we_n,
   input wire logic readback_enable_n,
   input wire logic sw_update_n,
   input wire logic sw_reset_n,
   input wire logic [4:0] sw_addr,
   input wire logic [6:0] sw_data_o,
   input wire logic sw_data_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // ****************************************
   // Pin sequencing
   // ****************************************
   we_needs_cs_a: assert property (!sw_we_n |-> !sw_cs_n)
      else $error("write strobe without chip select");
   we_stable_a: assert property (!sw_we_n |-> $stable(sw_data_o) && $stable(sw_addr) && sw_data_oe)
      else $error("data or address moved under write strobe");
   we_width_a: assert property ($fell(sw_we_n) |-> ##1 !sw_we_n ##1 sw_we_n)
      else $error("write strobe width wrong");
   we_reserved_a: assert property (!sw_we_n |-> sw_addr <= 5'h11 && sw_data_o[5:0] < 6'h21)
      else $error("reserved code written");
   upd_cs_a: assert property (!sw_update_n |-> !sw_cs_n && sw_we_n)
      else $error("update without chip select");
   upd_width_a: assert property ($fell(sw_update_n) |-> ##1 !sw_update_n ##1 sw_update_n)
      else $error("update width wrong");
   rb_release_a: assert property (!readback_enable_n |-> !sw_data_oe && !sw_cs_n)
      else $error("host drives data during readback");
   rb_addr_a: assert property (!readback_enable_n |-> sw_addr < 5'h11)
      else $error("readback of broadcast or reserved address");
   rst_width_a: assert property ($fell(sw_reset_n) |-> ##1 !sw_reset_n ##1 sw_reset_n)
      else $error("reset pulse width wrong");
endmodule

bind crosspoint_host crosspoint_host_checker u_crosspoint_host_checker (.hclk, .hresetn, .sw_cs_n, .sw_we_n,
   .readback_enable_n, .sw_update_n, .sw_reset_n, .sw_addr, .sw_data_o, .sw_data_oe);

// ---- tb/crosspoint_model.sv ----
module crosspoint_model (
   // Clock
   input wire logic hclk,
   // Control pins
   input wire logic cs_n,
   input wire logic we_n,
   input wire logic readback_enable_n,
   input wire logic update_n,
   input wire logic reset_n,
   input wire logic [4:0] addr,
   input wire logic [6:0] data_o,
   input wire logic data_oe,
   // Resolved data wire
   output logic [6:0] pins
);
   timeunit 1ns;
   timeprecision 1ps;
   // Left unknown at start: before a write, only the reset pin's clear of active bit 6 defines them
   logic [6:0] pending_connection_latch [17];
   logic [6:0] active_connection_latch [17];
   logic [6:0] idle_q = 7'h55;
   logic drive;

   // ****************************************
   // Data wire
   // ****************************************
   // Released wire toggles so a stale value never passes
   always @(posedge hclk) idle_q <= ~idle_q;
   assign drive = !cs_n && !readback_enable_n;
   assign pins = data_oe ? (drive ? 7'bxxxxxxx : data_o) :
                 (drive && addr < 5'h11) ? active_connection_latch[addr] : idle_q;

   // ****************************************
   // Latches, sampled at mid-cycle
   // ****************************************
   always @(negedge hclk) begin
      if (!cs_n && !we_n) begin
         if (addr == 5'h11) begin
            for (int i = 0; i < 17; i++) pending_connection_latch[i] = pins;
         end else if (addr < 5'h11) begin
            pending_connection_latch[addr] = pins;
         end
      end
      if (!cs_n && !update_n) begin
         for (int i = 0; i < 17; i++) active_connection_latch[i] = pending_connection_latch[i];
      end
      if (!reset_n) begin
         for (int i = 0; i < 17; i++) active_connection_latch[i][6] = 1'b0;
      end
   end
endmodule

// ---- tb/crosspoint_host_tb_top.sv ----
module crosspoint_host_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout, hresp, sw_cs_n, sw_we_n, readback_enable_n, sw_update_n, sw_reset_n, sw_data_oe;
   logic [31:0] hrdata;
   logic [4:0] sw_addr;
   logic [6:0] sw_data_o, sw_data_i;
   int err_total = 0;
   int cmp_count = 0;

   always #5 hclk = ~hclk;

   crosspoint_host u_crosspoint_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sw_cs_n(sw_cs_n), .sw_we_n(sw_we_n),
      .readback_enable_n(readback_enable_n), .sw_update_n(sw_update_n), .sw_reset_n(sw_reset_n),
      .sw_addr(sw_addr), .sw_data_o(sw_data_o), .sw_data_oe(sw_data_oe), .sw_data_i(sw_data_i));
   crosspoint_model u_crosspoint_model (.hclk(hclk), .cs_n(sw_cs_n), .we_n(sw_we_n),
      .readback_enable_n(readback_enable_n), .update_n(sw_update_n), .reset_n(sw_reset_n), .addr(sw_addr),
      .data_o(sw_data_o), .data_oe(sw_data_oe), .pins(sw_data_i));

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic print_verdict;
      if (err_total == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Hready sampled at the rising edge; read data taken at the edge closing the data phase
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic status(output logic [31:0] r);
      bus(1'b0, crosspoint_host_pkg::STATUS_OFFSET, 32'h0, r);
   endtask

   task automatic cmd(input logic [1:0] op, input logic [4:0] a, input logic [6:0] d);
      logic [31:0] r;
      bus(1'b1, crosspoint_host_pkg::CMD_OFFSET, {9'h0, d, 3'h0, a, 6'h0, op}, r);
      r = 32'h1;
      while (r[0] !== 1'b0) status(r);
   endtask

   function automatic logic [6:0] word(input int i);
      return {i[0], 6'(2 * i)};
   endfunction

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_regs;
      logic [31:0] r;
      check("pins idle", {sw_cs_n, sw_we_n, readback_enable_n, sw_update_n, sw_reset_n}, 32'h1F);
      check("okay response", {hreadyout, hresp}, 32'h2);
      bus(1'b0, crosspoint_host_pkg::CMD_OFFSET, 32'h0, r);
      check("cmd reset", r, 32'h0);
      status(r);
      check("status reset", r, 32'h0);
      bus(1'b1, 32'h0000_0010, 32'hFFFF_FFFF, r);
      bus(1'b0, 32'h0000_0010, 32'h0, r);
      check("unmapped", r, 32'h0);
   endtask

   task automatic t_program;
      logic [31:0] r;
      cmd(crosspoint_host_pkg::OP_RESET, 5'h00, 7'h00);
      cmd(crosspoint_host_pkg::OP_UPDATE, 5'h00, 7'h00);
      status(r);
      check("early update refused", r[1:0], 32'h2);
      bus(1'b1, crosspoint_host_pkg::STATUS_OFFSET, 32'h2, r);
      for (int i = 0; i < 17; i++) cmd(crosspoint_host_pkg::OP_WRITE, 5'(i), word(i));
      check("active before update", u_crosspoint_model.active_connection_latch[3][6], 32'h0);
      cmd(crosspoint_host_pkg::OP_UPDATE, 5'h00, 7'h00);
      for (int i = 0; i < 17; i++) begin
         check("active", u_crosspoint_model.active_connection_latch[i], 32'(word(i)));
         cmd(crosspoint_host_pkg::OP_READ, 5'(i), 7'h00);
         status(r);
         check("readback", r, {17'h0, word(i), 8'h04});
      end
      cmd(crosspoint_host_pkg::OP_WRITE, 5'h05, 7'h5F);
      check("pending", u_crosspoint_model.pending_connection_latch[5], 32'h5F);
      check("held", u_crosspoint_model.active_connection_latch[5], 32'(word(5)));
   endtask

   task automatic t_broadcast;
      logic [31:0] r;
      logic [13:0] bad [3] = '{{2'h3, 5'h11, 7'h00}, {2'h1, 5'h12, 7'h41}, {2'h1, 5'h03, 7'h21}};
      cmd(crosspoint_host_pkg::OP_WRITE, 5'h11, 7'h47);
      cmd(crosspoint_host_pkg::OP_WRITE, 5'h10, 7'h60);
      cmd(crosspoint_host_pkg::OP_UPDATE, 5'h00, 7'h00);
      for (int i = 0; i < 17; i++) begin
         check("broadcast", u_crosspoint_model.active_connection_latch[i], (i == 16) ? 32'h60 : 32'h47);
      end
      for (int k = 0; k < 3; k++) begin
         cmd(bad[k][13:12], bad[k][11:7], bad[k][6:0]);
         status(r);
         check("refused", r[1:0], 32'h2);
         bus(1'b1, crosspoint_host_pkg::STATUS_OFFSET, 32'h2, r);
         status(r);
         check("error cleared", r[1], 32'h0);
      end
      check("refusal harmless", u_crosspoint_model.pending_connection_latch[3], 32'h47);
   endtask

   task automatic t_reset;
      logic [31:0] r;
      cmd(crosspoint_host_pkg::OP_RESET, 5'h00, 7'h00);
      for (int i = 0; i < 17; i++) begin
         check("reset active", u_crosspoint_model.active_connection_latch[i], (i == 16) ? 32'h20 : 32'h07);
         check("reset pending", u_crosspoint_model.pending_connection_latch[i], (i == 16) ? 32'h60 : 32'h47);
      end
      cmd(crosspoint_host_pkg::OP_READ, 5'h10, 7'h00);
      status(r);
      check("readback after reset", r, 32'h2004);
   endtask

   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_regs();
      t_program();
      t_broadcast();
      t_reset();
      print_verdict();
   end

   // Whole run needs about 800 cycles
   initial begin
      #200000;
      err_total++;
      print_verdict();
   end
endmodule
